//--- hdl/tsc_defines.vh
// constants for the thermal sensor control register block
// assumes a 32-bit classic wishbone slave port and a 20 MHz core clock
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH

// byte addresses on the register bus
`define TSC_ADR_W 8
`define TSC_OFS_CONTROL 8'h60
`define TSC_OFS_LOCK 8'h64
`define TSC_OFS_STATUS 8'h68

// control register fields
`define TSC_CTL_POWER 7
`define TSC_CTL_HYST_HI 5
`define TSC_CTL_HYST_LO 4
`define TSC_CTL_OSEL 1
`define TSC_CTL_SEM 0
`define TSC_CTL_RESET 8'h00
`define TSC_CTL_WMASK 8'hb2

// lock register fields
`define TSC_LOCK_BIT 7
`define TSC_LOCK_RESET 8'h00

// status register fields
`define TSC_ST_READY 0
`define TSC_ST_CAT 1
`define TSC_ST_HOT 2
`define TSC_ST_OUT 3

// power-up settle time
`define TSC_CLK_HZ 20000000
`define TSC_SETTLE_NS 5000
`define TSC_SETTLE_CYC ((`TSC_SETTLE_NS * (`TSC_CLK_HZ / 1000000) + 999) / 1000)
`define TSC_SETTLE_W 8

`endif

//--- hdl/tsc_semaphore.v
// software ownership semaphore bit that sets itself on read
// assumes one-cycle read and write pulses from the bus front end
`timescale 1ns/1ns
`default_nettype none
`include "tsc_defines.vh"

module tsc_semaphore
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // access strobes for the control register
  input wire rd_i,
  input wire wr_i,
  input wire wr_bit_i,
  // current value seen by a read
  output reg in_use_o
);

  ////////////////////////////////////////////////////////////////////////////
  // set after read
  // a read returns the old value and leaves the bit set behind it
  // write one clears
  // a write of 1 clears it, a write of 0 is ignored
  always @(posedge clk_i)
  begin
    if (rst_i)
      in_use_o <= 1'b0;
    else if (wr_i & wr_bit_i)
      in_use_o <= 1'b0;
    else if (rd_i)
      in_use_o <= 1'b1;
  end

endmodule
`default_nettype wire

//--- hdl/tsc_top.v
// thermal sensor control register with lock and status, on classic wishbone
// assumes comparator inputs synchronous to clk_i; 32-bit bus, byte lane 0 used
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tsc_defines.vh"

module tsc_top
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [`TSC_ADR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  // comparator results from the analog sensor
  input wire cat_cmp_i,
  input wire hot_cmp_i,
  // controls to the sensor
  output reg sensor_power_enable_o,
  output reg [1:0] trip_hysteresis_amount_o,
  output reg hysteresis_enable_o,
  output reg sensor_out_o,
  output reg catastrophic_lock_o,
  output reg sensor_ready_o
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function adr_hit;
    input [`TSC_ADR_W-1:0] adr;
    input [`TSC_ADR_W-1:0] ofs;
    begin
      adr_hit = (adr[`TSC_ADR_W-1:2] == ofs[`TSC_ADR_W-1:2]);
    end
  endfunction

  wire wr_pulse;
  wire rd_pulse;
  wire lane0;
  wire hit_ctl;
  wire hit_lock;
  wire hit_st;
  wire ctl_wr;
  wire ctl_rd;
  wire lock_wr;
  wire sem_bit;
  reg comparator_output_select;
  reg [31:0] rdata;
  reg [`TSC_SETTLE_W-1:0] settle_cnt;
  reg [7:0] next_rbyte;

  // reset images kept at byte width so single fields can be picked without truncation
  localparam [7:0] CTL_RST = `TSC_CTL_RESET;
  localparam [7:0] LOCK_RST = `TSC_LOCK_RESET;

  assign hit_ctl = adr_hit(adr_i, `TSC_OFS_CONTROL);
  assign hit_lock = adr_hit(adr_i, `TSC_OFS_LOCK);
  assign hit_st = adr_hit(adr_i, `TSC_OFS_STATUS);
  assign ctl_wr = wr_pulse & lane0 & hit_ctl;
  assign ctl_rd = rd_pulse & hit_ctl;
  assign lock_wr = wr_pulse & lane0 & hit_lock;
  assign dat_o = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  tsc_wb_slave u_bus
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .sel_i(sel_i),
    .ack_o(ack_o),
    .wr_pulse_o(wr_pulse),
    .rd_pulse_o(rd_pulse),
    .lane0_o(lane0)
  );

  // semaphore instance
  // a read of any byte of the control word counts as a read of the bit
  tsc_semaphore u_sem
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rd_i(ctl_rd),
    .wr_i(ctl_wr),
    .wr_bit_i(dat_i[`TSC_CTL_SEM]),
    .in_use_o(sem_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // catastrophic lock
  // sticky once written to 1; only reset reopens the power and output select fields, so a
  // runaway driver cannot unlock the shutdown settings
  always @(posedge clk_i)
  begin
    if (rst_i)
      catastrophic_lock_o <= LOCK_RST[`TSC_LOCK_BIT];
    else if (lock_wr & dat_i[`TSC_LOCK_BIT])
      catastrophic_lock_o <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sensor_power_enable_o <= CTL_RST[`TSC_CTL_POWER];
      comparator_output_select <= CTL_RST[`TSC_CTL_OSEL];
      trip_hysteresis_amount_o <= CTL_RST[`TSC_CTL_HYST_HI:`TSC_CTL_HYST_LO];
    end
    else if (ctl_wr)
    begin
      trip_hysteresis_amount_o <= dat_i[`TSC_CTL_HYST_HI:`TSC_CTL_HYST_LO];
      if (!catastrophic_lock_o)
      begin
        sensor_power_enable_o <= dat_i[`TSC_CTL_POWER];
        comparator_output_select <= dat_i[`TSC_CTL_OSEL];
      end
    end
  end

  // hysteresis enable decode
  // any non-zero code turns hysteresis on at 1, 2 or 3 degrees
  always @(posedge clk_i)
  begin
    if (rst_i)
      hysteresis_enable_o <= 1'b0;
    else
      hysteresis_enable_o <= |trip_hysteresis_amount_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output select mux
  // registered so the output cannot glitch while the select changes
  always @(posedge clk_i)
  begin
    if (rst_i)
      sensor_out_o <= 1'b0;
    else if (comparator_output_select)
      sensor_out_o <= hot_cmp_i;
    else
      sensor_out_o <= cat_cmp_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // settle time flag
  // software may poll this before arming throttling; the hardware itself
  // does not block throttle enables, that stays software's duty
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      settle_cnt <= {`TSC_SETTLE_W{1'b0}};
      sensor_ready_o <= 1'b0;
    end
    else if (!sensor_power_enable_o)
    begin
      settle_cnt <= {`TSC_SETTLE_W{1'b0}};
      sensor_ready_o <= 1'b0;
    end
    else if (settle_cnt == `TSC_SETTLE_CYC - 1)
      sensor_ready_o <= 1'b1;
    else
      settle_cnt <= settle_cnt + {{(`TSC_SETTLE_W-1){1'b0}}, 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data select; unmapped addresses read as zero
  always @*
  begin
    next_rbyte = 8'h00;
    if (hit_ctl)
    begin
      next_rbyte[`TSC_CTL_POWER] = sensor_power_enable_o;
      next_rbyte[`TSC_CTL_HYST_HI:`TSC_CTL_HYST_LO] = trip_hysteresis_amount_o;
      next_rbyte[`TSC_CTL_OSEL] = comparator_output_select;
      next_rbyte[`TSC_CTL_SEM] = sem_bit;
    end
    else if (hit_lock)
      next_rbyte[`TSC_LOCK_BIT] = catastrophic_lock_o;
    else if (hit_st)
    begin
      next_rbyte[`TSC_ST_READY] = sensor_ready_o;
      next_rbyte[`TSC_ST_CAT] = cat_cmp_i;
      next_rbyte[`TSC_ST_HOT] = hot_cmp_i;
      next_rbyte[`TSC_ST_OUT] = sensor_out_o;
    end
  end

  // read data captured at the take edge, shown with ack
  always @(posedge clk_i)
  begin
    if (rst_i)
      rdata <= 32'h00000000;
    else if (rd_pulse)
      rdata <= {24'h000000, next_rbyte};
  end

endmodule
`default_nettype wire

//--- hdl/tsc_wb_slave.v
// classic wishbone slave front end for the thermal sensor control block
// assumes a single-master classic cycle, one answer per request
`timescale 1ns/1ns
`default_nettype none
`include "tsc_defines.vh"

module tsc_wb_slave
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone side
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] sel_i,
  output reg ack_o,
  // register side strobes
  output wire wr_pulse_o,
  output wire rd_pulse_o,
  output wire lane0_o
);

  ////////////////////////////////////////////////////////////////////////////
  // a request is taken in the first cycle it is seen; ack follows one edge
  // later, so the held request cannot be taken twice
  wire take;
  assign take = cyc_i & stb_i & ~ack_o;
  assign wr_pulse_o = take & we_i;
  assign rd_pulse_o = take & ~we_i;
  assign lane0_o = sel_i[0];

  // ack for one cycle per request
  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= take;
  end

endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the thermal sensor control block
// assumes tsc_top answers each classic wishbone request with one ack
`timescale 1ns/1ns
`default_nettype none
`include "tsc_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, cat_cmp_i = 0, hot_cmp_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, pwr, hen, sout, lock, rdy;
  logic [1:0] hyst;
  int fail_count = 0, n_compared = 0;
  // rows: write flag, address, write data, expected read data (after a write: expected power and hysteresis)
  logic [27:0] rows [15] = '{28'h0600000, 28'h0600001, 28'h1600100, 28'h0600000, 28'h160feb0,
    28'h06000b3, 28'h1600000, 28'h0600001, 28'h1609190, 28'h0600090, 28'h160a3a0, 28'h06000a2,
    28'h17c00a0, 28'h07c0000, 28'h06000a3};
  tsc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cat_cmp_i(cat_cmp_i), .hot_cmp_i(hot_cmp_i),
    .sensor_power_enable_o(pwr), .trip_hysteresis_amount_o(hyst), .hysteresis_enable_o(hen),
    .sensor_out_o(sout), .catastrophic_lock_o(lock), .sensor_ready_o(rdy));
  //////////////////////////////////////////////////////////////
  // 20 mhz clock
  always #25 clk_i = ~clk_i;
  // one classic cycle; waits for ack as long as it takes, the hang guard bounds a dead slave
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // verdict and end of run
  task report_and_stop;
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  initial
  begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////
  // row table, then lane, select, lock and reset cases
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      bus(rows[i][24], rows[i][23:16], {24'h0, rows[i][15:8]}, 4'hf);
      if (rows[i][24]) `CHK({pwr, hyst}, {rows[i][7], rows[i][5:4]})
      else `CHK(rd, {24'h0, rows[i][7:0]})
    end
    bus(1, 8'h60, 32'h01, 4'he);
    bus(0, 8'h60, 32'h0, 4'hf);
    `CHK(rd, 32'ha3)
    hot_cmp_i <= 1;
    repeat (2) @(posedge clk_i);
    `CHK(sout, 1'b1)
    bus(1, 8'h60, 32'h80, 4'hf);
    `CHK(sout, 1'b0)
    bus(1, 8'h64, 32'h80, 4'hf);
    `CHK(lock, 1'b1)
    bus(1, 8'h60, 32'h12, 4'hf);
    `CHK({pwr, hyst, sout}, 4'ha)
    bus(0, 8'h60, 32'h0, 4'hf);
    `CHK(rd, 32'h91)
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, 8'h60, 32'h0, 4'hf);
    `CHK({rd, lock}, 33'h0)
    // a thread that read 0 but wants no exclusive use writes 1 back
    bus(1, 8'h60, 32'h01, 4'h1);
    bus(0, 8'h60, 32'h0, 4'hf);
    `CHK(rd, 32'h00)
    // power on; ready only once the settle time has run
    bus(1, 8'h60, 32'h80, 4'hf);
    repeat (`TSC_SETTLE_CYC - 8) @(posedge clk_i);
    `CHK(rdy, 1'b0)
    repeat (8) @(posedge clk_i);
    `CHK(rdy, 1'b1)
    bus(0, 8'h68, 32'h0, 4'hf);
    `CHK(rd, 32'h05)
    // nothing is armed here, so power may go straight off
    bus(1, 8'h60, 32'h00, 4'hf);
    `CHK({pwr, rdy}, 2'h0)
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- verif/tsc_checker.sv
// assertion checker for the thermal sensor control block
// assumes it is bound to tsc_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "tsc_defines.vh"
module tsc_checker
(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic cat_cmp_i,
  input wire logic hot_cmp_i,
  input wire logic sensor_power_enable_o,
  input wire logic [1:0] trip_hysteresis_amount_o,
  input wire logic hysteresis_enable_o,
  input wire logic sensor_out_o,
  input wire logic catastrophic_lock_o,
  input wire logic sensor_ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // control write taken; request data still held at the ack edge
  wire ctl_wr = cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i[7:2] == 6'h18;
  //////////////////////////////////////////////////////////////
  // bus answer timing
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  // control fields
  property p_power; ctl_wr && !catastrophic_lock_o |=> sensor_power_enable_o == dat_i[7]; endproperty
  a_power: assert property (p_power) else $error("power bit not written");
  property p_hyst; ctl_wr |=> trip_hysteresis_amount_o == dat_i[5:4]; endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis not written");
  property p_hen; hysteresis_enable_o == (|$past(trip_hysteresis_amount_o)); endproperty
  a_hen: assert property (p_hen) else $error("hysteresis enable wrong");
  property p_out; !$past(rst_i) && $past(cat_cmp_i) == $past(hot_cmp_i) |-> sensor_out_o == $past(cat_cmp_i);
  endproperty
  a_out: assert property (p_out) else $error("sensor output not a comparator");
  property p_locked; ctl_wr && catastrophic_lock_o |=> $stable(sensor_power_enable_o); endproperty
  a_locked: assert property (p_locked) else $error("power changed while locked");
  property p_sticky; catastrophic_lock_o |=> catastrophic_lock_o; endproperty
  a_sticky: assert property (p_sticky) else $error("lock cleared without reset");
  property p_rsvd; ack_o && !we_i && adr_i[7:2] == 6'h18 |-> dat_o[31:8] == 24'h0 && !dat_o[6] && dat_o[3:2] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  // main scenarios reached
  c_locked: cover property (ctl_wr && catastrophic_lock_o);
  c_hyst3: cover property (trip_hysteresis_amount_o == 2'h3);
  c_hot: cover property (ctl_wr ##1 sensor_out_o);
endmodule
bind tsc_top tsc_checker chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cat_cmp_i(cat_cmp_i),
  .hot_cmp_i(hot_cmp_i), .sensor_power_enable_o(sensor_power_enable_o),
  .trip_hysteresis_amount_o(trip_hysteresis_amount_o), .hysteresis_enable_o(hysteresis_enable_o),
  .sensor_out_o(sensor_out_o), .catastrophic_lock_o(catastrophic_lock_o), .sensor_ready_o(sensor_ready_o));
`default_nettype wire
